// File: core/timer16_pkg.sv
// Constants shared by the 16-bit one-shot/continuous timer.
// Assumes a single 40 MHz clock and a simple strobed register port.
package timer16_pkg;
	localparam int unsigned CLK_HZ = 40000000;
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_CNT_HI = 4'h1;
	localparam logic [3:0] OFS_CNT_LO = 4'h2;
	localparam logic [3:0] OFS_RLD_HI = 4'h3;
	localparam logic [3:0] OFS_RLD_LO = 4'h4;
	localparam logic [3:0] OFS_STATUS = 4'h5;
	localparam logic [3:0] OFS_MASK = 4'h6;
	localparam logic [3:0] OFS_ALTF = 4'h7;
	// Control bits
	localparam int CTRL_EN = 7;
	localparam int CTRL_CONT = 6;
	localparam int CTRL_INITLVL = 5;
	localparam int CTRL_PRE_LSB = 0;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [15:0] COUNT_RST = 16'h0000;
	localparam logic [15:0] COUNT_RELOAD = 16'h0001;
	localparam logic [15:0] RELOAD_RST = 16'h0000;
	localparam logic [6:0] PRESCALE_RST = 7'h00;
	// Reload zero spans the whole count range
	localparam logic [16:0] FULL_SPAN = 17'h10000;
	localparam int ST_MATCH = 0;
	localparam int ST_WRAP = 1;
endpackage

// File: core/timer16_oneshot_continuous.sv
// 16-bit up-counting timer with prescaler, one-shot and continuous modes.
// Assumes a register master with one-cycle strobes and synchronous pins.
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

module timer16_oneshot_continuous (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Register port
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdata,
	// Pins
	input wire logic timer_input_pin,
	input wire logic portDirOe,
	input wire logic portDataOut,
	output logic timer_output_pin,
	output logic timer_output_pin_oe,
	// Interrupts
	output logic irqPulse,
	output logic irq
);
	logic [7:0] ctrl_q;
	logic [15:0] count_q;
	logic [15:0] reload_q;
	logic [6:0] pre_q;
	logic [1:0] status_q;
	logic [1:0] mask_q;
	logic [7:0] alt_func_select_lo_q;
	logic outLvl_q;
	logic enable;
	logic tick;
	logic match;
	logic [6:0] preMask;

	assign enable = ctrl_q[timer16_pkg::CTRL_EN];

	function automatic logic [6:0] pre_mask_of(input logic [2:0] sel);
		pre_mask_of = 7'(({7'h00, 1'b1} << sel) - 8'h01);
	endfunction

	assign preMask = pre_mask_of(ctrl_q[timer16_pkg::CTRL_PRE_LSB +: 3]);
	// Input pin deliberately unused: only the system clock drives counting
	assign tick = enable && ((pre_q & preMask) == preMask);
	// Reload zero matches at a full 65536 span since the count rolls back to 0000H
	assign match = tick && (count_q == reload_q);

	// Prescaler
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pre_q <= timer16_pkg::PRESCALE_RST;
		end else if (!enable || tick) begin
			pre_q <= timer16_pkg::PRESCALE_RST;
		end else begin
			pre_q <= 7'(pre_q + 7'h01);
		end
	end

	// Counter
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			count_q <= timer16_pkg::COUNT_RST;
		end else if (regWr && regAddr == timer16_pkg::OFS_CNT_HI) begin
			count_q[15:8] <= regWdata;
		end else if (regWr && regAddr == timer16_pkg::OFS_CNT_LO) begin
			count_q[7:0] <= regWdata;
		end else if (match) begin
			count_q <= timer16_pkg::COUNT_RELOAD;
		end else if (tick) begin
			count_q <= 16'(count_q + 16'h0001);
		end
	end

	// Control: a software write beats the one-shot self-disable
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_q <= timer16_pkg::CTRL_RST;
		end else if (regWr && regAddr == timer16_pkg::OFS_CTRL) begin
			ctrl_q <= regWdata;
		end else if (match && !ctrl_q[timer16_pkg::CTRL_CONT]) begin
			ctrl_q[timer16_pkg::CTRL_EN] <= 1'b0;
		end
	end

	// Reload value, written byte by byte
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			reload_q <= timer16_pkg::RELOAD_RST;
		end else if (regWr && regAddr == timer16_pkg::OFS_RLD_HI) begin
			reload_q[15:8] <= regWdata;
		end else if (regWr && regAddr == timer16_pkg::OFS_RLD_LO) begin
			reload_q[7:0] <= regWdata;
		end
	end

	// Alternate function select
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			alt_func_select_lo_q <= 8'h00;
		end else if (regWr && regAddr == timer16_pkg::OFS_ALTF) begin
			alt_func_select_lo_q <= regWdata;
		end
	end

	// Interrupt mask
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			mask_q <= 2'h0;
		end else if (regWr && regAddr == timer16_pkg::OFS_MASK) begin
			mask_q <= regWdata[1:0];
		end
	end

	// Sticky status: a set in the same cycle wins over a write-one clear
	logic [1:0] stSet;
	logic stClrWr;
	assign stSet[timer16_pkg::ST_MATCH] = match;
	assign stSet[timer16_pkg::ST_WRAP] = tick && !match && count_q == 16'hFFFF;
	assign stClrWr = regWr && regAddr == timer16_pkg::OFS_STATUS;
	for (genvar i = 0; i < 2; i++) begin : g_status
		always_ff @(posedge ref_clk or negedge arst_n) begin
			if (!arst_n) begin
				status_q[i] <= 1'b0;
			end else if (stSet[i]) begin
				status_q[i] <= 1'b1;
			end else if (stClrWr && regWdata[i]) begin
				status_q[i] <= 1'b0;
			end
		end
	end

	// Read data
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			regRdata <= 8'h00;
		end else if (regRd) begin
			unique case (regAddr)
				timer16_pkg::OFS_CTRL: regRdata <= ctrl_q;
				timer16_pkg::OFS_CNT_HI: regRdata <= count_q[15:8];
				timer16_pkg::OFS_CNT_LO: regRdata <= count_q[7:0];
				timer16_pkg::OFS_RLD_HI: regRdata <= reload_q[15:8];
				timer16_pkg::OFS_RLD_LO: regRdata <= reload_q[7:0];
				timer16_pkg::OFS_STATUS: regRdata <= {6'h00, status_q};
				timer16_pkg::OFS_MASK: regRdata <= {6'h00, mask_q};
				timer16_pkg::OFS_ALTF: regRdata <= alt_func_select_lo_q;
				default: regRdata <= 8'h00;
			endcase
		end else begin
			regRdata <= 8'h00;
		end
	end

	// Output pin: level set by software, inverted one cycle per one-shot match
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			outLvl_q <= 1'b0;
			timer_output_pin <= 1'b0;
			timer_output_pin_oe <= 1'b0;
		end else begin
			outLvl_q <= ctrl_q[timer16_pkg::CTRL_INITLVL];
			if (alt_func_select_lo_q[0]) begin
				timer_output_pin_oe <= 1'b1;
				timer_output_pin <= (match && !ctrl_q[timer16_pkg::CTRL_CONT]) ? !outLvl_q : outLvl_q;
			end else begin
				timer_output_pin_oe <= portDirOe;
				timer_output_pin <= portDataOut;
			end
		end
	end

	// Interrupt outputs
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			irqPulse <= 1'b0;
			irq <= 1'b0;
		end else begin
			irqPulse <= match;
			irq <= |(status_q & mask_q);
		end
	end

	logic unusedPin;
	assign unusedPin = timer_input_pin;

	// Checker helper: cycles between reloads, valid only across untouched continuous passes
	logic [23:0] gapCnt_q;
	logic gapValid_q;
	logic [23:0] gapExpect;
	assign gapExpect = (reload_q == 16'h0000) ?
		(24'(timer16_pkg::FULL_SPAN) << ctrl_q[timer16_pkg::CTRL_PRE_LSB +: 3]) :
		(24'(reload_q) << ctrl_q[timer16_pkg::CTRL_PRE_LSB +: 3]);
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			gapCnt_q <= 24'h000000;
			gapValid_q <= 1'b0;
		end else if (regWr) begin
			gapValid_q <= 1'b0;
		end else if (match) begin
			gapCnt_q <= 24'h000001;
			gapValid_q <= ctrl_q[timer16_pkg::CTRL_CONT];
		end else begin
			gapCnt_q <= 24'(gapCnt_q + 24'h000001);
		end
	end

	a_oneshot_disable: assert property (@(posedge ref_clk) disable iff (!arst_n)
		match && !ctrl_q[timer16_pkg::CTRL_CONT] && !regWr |=> !enable)
		else $error("one-shot did not disable");
	a_reload_value: assert property (@(posedge ref_clk) disable iff (!arst_n)
		match && !regWr |=> count_q == 16'h0001)
		else $error("count not reloaded to 1");
	a_wrap_zero: assert property (@(posedge ref_clk) disable iff (!arst_n)
		tick && !match && count_q == 16'hFFFF && !regWr |=> count_q == 16'h0000)
		else $error("counter did not wrap");
	a_count_step: assert property (@(posedge ref_clk) disable iff (!arst_n)
		tick && !match && !regWr |=> count_q == 16'($past(count_q) + 16'h0001))
		else $error("count did not step");
	a_hold_idle: assert property (@(posedge ref_clk) disable iff (!arst_n)
		!tick && !regWr |=> $stable(count_q))
		else $error("count moved without tick");
	a_pre_clear: assert property (@(posedge ref_clk) disable iff (!arst_n)
		!enable |=> pre_q == 7'h00)
		else $error("prescaler not cleared");
	a_irq_pulse: assert property (@(posedge ref_clk) disable iff (!arst_n)
		!match |=> !irqPulse)
		else $error("irq pulse without match");
	a_irq_follows: assert property (@(posedge ref_clk) disable iff (!arst_n)
		match |=> irqPulse)
		else $error("irq missing after match");
	a_pin_restore: assert property (@(posedge ref_clk) disable iff (!arst_n)
		alt_func_select_lo_q[0] && match && !ctrl_q[timer16_pkg::CTRL_CONT] && !regWr
		|=> timer_output_pin != outLvl_q ##1 timer_output_pin == $past(outLvl_q))
		else $error("pin did not pulse once");
	a_pin_dir: assert property (@(posedge ref_clk) disable iff (!arst_n)
		alt_func_select_lo_q[0] |=> timer_output_pin_oe)
		else $error("alt function lost direction");
	a_tick_div1: assert property (@(posedge ref_clk) disable iff (!arst_n)
		enable && ctrl_q[2:0] == 3'h0 |-> tick)
		else $error("prescale 1 missed tick");

	// Period, interrupt and register side checks
	a_cont_period: assert property (@(posedge ref_clk) disable iff (!arst_n)
		match && gapValid_q |-> gapCnt_q == gapExpect)
		else $error("continuous period wrong");
	a_cont_keep_en: assert property (@(posedge ref_clk) disable iff (!arst_n)
		match && ctrl_q[timer16_pkg::CTRL_CONT] && !regWr |=> enable)
		else $error("continuous mode stopped");
	a_tick_gated: assert property (@(posedge ref_clk) disable iff (!arst_n)
		!enable |-> !tick)
		else $error("tick while disabled");
	a_pre_step: assert property (@(posedge ref_clk) disable iff (!arst_n)
		enable && !tick |=> pre_q == 7'($past(pre_q) + 7'h01))
		else $error("prescaler did not step");
	a_irq_raise: assert property (@(posedge ref_clk) disable iff (!arst_n)
		|(status_q & mask_q) |=> irq)
		else $error("irq level missing");
	a_irq_drop: assert property (@(posedge ref_clk) disable iff (!arst_n)
		!(|(status_q & mask_q)) |=> !irq)
		else $error("irq level without cause");
	a_status_set: assert property (@(posedge ref_clk) disable iff (!arst_n)
		match |=> status_q[timer16_pkg::ST_MATCH])
		else $error("match status not set");
	a_status_hold: assert property (@(posedge ref_clk) disable iff (!arst_n)
		status_q[0] && !(stClrWr && regWdata[0]) |=> status_q[0])
		else $error("match status lost");
	a_status_clear: assert property (@(posedge ref_clk) disable iff (!arst_n)
		stClrWr && regWdata[0] && !match |=> !status_q[0])
		else $error("match status not cleared");
	a_wrap_flag: assert property (@(posedge ref_clk) disable iff (!arst_n)
		tick && !match && count_q == 16'hFFFF |=> status_q[timer16_pkg::ST_WRAP])
		else $error("wrap status not set");
	a_rdata_idle: assert property (@(posedge ref_clk) disable iff (!arst_n)
		!regRd |=> regRdata == 8'h00)
		else $error("read data without read");
	a_rdata_cnt_hi: assert property (@(posedge ref_clk) disable iff (!arst_n)
		regRd && regAddr == timer16_pkg::OFS_CNT_HI |=> regRdata == $past(count_q[15:8]))
		else $error("count high byte read wrong");
	a_rdata_cnt_lo: assert property (@(posedge ref_clk) disable iff (!arst_n)
		regRd && regAddr == timer16_pkg::OFS_CNT_LO |=> regRdata == $past(count_q[7:0]))
		else $error("count low byte read wrong");
	a_cnt_hi_write: assert property (@(posedge ref_clk) disable iff (!arst_n)
		regWr && regAddr == timer16_pkg::OFS_CNT_HI |=> count_q[15:8] == $past(regWdata))
		else $error("count high byte write lost");
	a_cnt_lo_write: assert property (@(posedge ref_clk) disable iff (!arst_n)
		regWr && regAddr == timer16_pkg::OFS_CNT_LO |=> count_q[7:0] == $past(regWdata))
		else $error("count low byte write lost");
	a_ctrl_write: assert property (@(posedge ref_clk) disable iff (!arst_n)
		regWr && regAddr == timer16_pkg::OFS_CTRL |=> ctrl_q == $past(regWdata))
		else $error("control write lost");
	a_rld_hi_write: assert property (@(posedge ref_clk) disable iff (!arst_n)
		regWr && regAddr == timer16_pkg::OFS_RLD_HI |=> reload_q[15:8] == $past(regWdata))
		else $error("reload high byte write lost");
	a_rld_lo_write: assert property (@(posedge ref_clk) disable iff (!arst_n)
		regWr && regAddr == timer16_pkg::OFS_RLD_LO |=> reload_q[7:0] == $past(regWdata))
		else $error("reload low byte write lost");
	a_altf_write: assert property (@(posedge ref_clk) disable iff (!arst_n)
		regWr && regAddr == timer16_pkg::OFS_ALTF |=> alt_func_select_lo_q == $past(regWdata))
		else $error("alternate function write lost");
	a_mask_write: assert property (@(posedge ref_clk) disable iff (!arst_n)
		regWr && regAddr == timer16_pkg::OFS_MASK |=> mask_q == $past(regWdata[1:0]))
		else $error("mask write lost");
	a_pin_cont: assert property (@(posedge ref_clk) disable iff (!arst_n)
		alt_func_select_lo_q[0] && ctrl_q[timer16_pkg::CTRL_CONT] |=> timer_output_pin == $past(outLvl_q))
		else $error("pin moved in continuous mode");
	a_port_oe: assert property (@(posedge ref_clk) disable iff (!arst_n)
		!alt_func_select_lo_q[0] |=> timer_output_pin_oe == $past(portDirOe))
		else $error("port direction not passed");
	a_port_data: assert property (@(posedge ref_clk) disable iff (!arst_n)
		!alt_func_select_lo_q[0] |=> timer_output_pin == $past(portDataOut))
		else $error("port data not passed");

	c_oneshot: cover property (@(posedge ref_clk) disable iff (!arst_n)
		match && !ctrl_q[timer16_pkg::CTRL_CONT]);
	c_cont: cover property (@(posedge ref_clk) disable iff (!arst_n)
		match && ctrl_q[timer16_pkg::CTRL_CONT]);
	c_wrap: cover property (@(posedge ref_clk) disable iff (!arst_n)
		status_q[timer16_pkg::ST_WRAP]);
	c_irq: cover property (@(posedge ref_clk) disable iff (!arst_n) irq);
	c_period: cover property (@(posedge ref_clk) disable iff (!arst_n)
		match && gapValid_q);
endmodule

// File: dv/timer16_oneshot_continuous_tb.sv
// Self-checking bench for the 16-bit one-shot/continuous timer.
// Assumes the register map and timing fixed in timer16_pkg.
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin num_errors++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module timer16_oneshot_continuous_tb;
	logic ref_clk = 0, arst_n = 0, regWr = 0, regRd = 0;
	logic timer_input_pin = 0, portDirOe = 0, portDataOut = 0;
	logic [3:0] regAddr = 4'h0;
	logic [7:0] regWdata = 8'h00, regRdata, d;
	logic timer_output_pin, timer_output_pin_oe, irqPulse, irq;
	int num_errors = 0, cmp_count = 0, n, r, p;
	timer16_oneshot_continuous DUT (.ref_clk(ref_clk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .timer_input_pin(timer_input_pin),
		.portDirOe(portDirOe), .portDataOut(portDataOut), .timer_output_pin(timer_output_pin),
		.timer_output_pin_oe(timer_output_pin_oe), .irqPulse(irqPulse), .irq(irq));
	always #12.5 ref_clk = ~ref_clk;
	// Noise on the input pin must never disturb the count
	always @(posedge ref_clk) timer_input_pin <= 1'($urandom);
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= v;
		@(posedge ref_clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge ref_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRd <= 1'b0;
		@(negedge ref_clk);
		d = regRdata;
	endtask
	task automatic waitIrq;
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (irqPulse !== 1'b1 && n < 70000);
	endtask
	// Measures the steady interval between reloads against the model
	task automatic cont(input int rv, input int pv, input logic [15:0] st);
		wr(timer16_pkg::OFS_CTRL, 8'h40 | 8'(pv));
		wr(timer16_pkg::OFS_CNT_HI, st[15:8]);
		wr(timer16_pkg::OFS_CNT_LO, st[7:0]);
		wr(timer16_pkg::OFS_RLD_HI, 8'(rv >> 8));
		wr(timer16_pkg::OFS_RLD_LO, 8'(rv));
		wr(timer16_pkg::OFS_CTRL, 8'hC0 | 8'(pv));
		waitIrq;
		waitIrq;
		`CHK(n, (rv == 0 ? 65536 : rv) << pv)
	endtask
	task test_done;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		void'($urandom(28));
		repeat (5) @(posedge ref_clk);
		arst_n <= 1'b1;
		rd(timer16_pkg::OFS_CTRL);
		`CHK(d, timer16_pkg::CTRL_RST)
		rd(4'hF);
		`CHK(d, 8'h00)
		// One-shot with pin and interrupt
		wr(timer16_pkg::OFS_ALTF, 8'h01);
		wr(timer16_pkg::OFS_MASK, 8'h01);
		wr(timer16_pkg::OFS_CTRL, 8'h20);
		wr(timer16_pkg::OFS_CNT_LO, 8'h01);
		wr(timer16_pkg::OFS_RLD_LO, 8'h06);
		wr(timer16_pkg::OFS_CTRL, 8'hA0);
		waitIrq;
		`CHK(n < 20, 1'b1)
		`CHK(timer_output_pin, 1'b0)
		`CHK(timer_output_pin_oe, 1'b1)
		@(negedge ref_clk);
		`CHK(timer_output_pin, 1'b1)
		`CHK(irqPulse, 1'b0)
		`CHK(irq, 1'b1)
		n = 0;
		repeat (20) begin
			@(negedge ref_clk);
			n += int'(irqPulse !== 1'b0);
		end
		`CHK(n, 0)
		rd(timer16_pkg::OFS_CTRL);
		`CHK(d, 8'h20)
		rd(timer16_pkg::OFS_CNT_LO);
		`CHK(d, 8'h01)
		rd(timer16_pkg::OFS_STATUS);
		`CHK(d, 8'h01)
		wr(timer16_pkg::OFS_STATUS, 8'h01);
		rd(timer16_pkg::OFS_STATUS);
		`CHK(d, 8'h00)
		`CHK(irq, 1'b0)
		// Port regains the pin when the alternate function is off
		@(posedge ref_clk);
		portDirOe <= 1'b0;
		portDataOut <= 1'b1;
		wr(timer16_pkg::OFS_ALTF, 8'h00);
		repeat (2) @(negedge ref_clk);
		`CHK(timer_output_pin_oe, 1'b0)
		`CHK(timer_output_pin, 1'b1)
		for (int i = 0; i < 6; i++) begin
			r = $urandom_range(6, 1);
			p = $urandom_range(3, 0);
			cont(r, p, 16'($urandom_range(r, 1)));
		end
		cont(3, 7, 16'h0001);
		cont(1, 0, 16'h0001);
		cont(0, 0, 16'hFFFF);
		wr(timer16_pkg::OFS_CTRL, 8'h00);
		wr(timer16_pkg::OFS_STATUS, 8'h03);
		cont(2, 0, 16'hFFFE);
		rd(timer16_pkg::OFS_STATUS);
		`CHK(d, 8'h03)
		wr(timer16_pkg::OFS_CTRL, 8'h00);
		wr(timer16_pkg::OFS_CNT_HI, 8'h12);
		wr(timer16_pkg::OFS_CNT_LO, 8'hA5);
		rd(timer16_pkg::OFS_CNT_HI);
		`CHK(d, 8'h12)
		rd(timer16_pkg::OFS_CNT_LO);
		`CHK(d, 8'hA5)
		test_done;
	end
	initial begin
		repeat (90000) @(posedge ref_clk);
		num_errors++;
		test_done;
	end
endmodule
